// ### shared/aux_pkg.sv
// Constants, codes and reset values shared by the auxiliary channel block.
// Assumes a single 200 MHz system clock drives every module that imports it.
package aux_pkg;
    localparam int AUX_CHANNELS = 3;
    localparam int AUX_ANALOG = 2;
    // Channel mode codes; code 2 means boost assist on the second and third channels.
    localparam logic [1:0] AUX_MODE_INPUT = 2'h0;
    localparam logic [1:0] AUX_MODE_OUTPUT = 2'h1;
    localparam logic [1:0] AUX_RADIO_POWER_ACTIVE_HIGH = 2'h2;
    localparam logic [1:0] AUX_RADIO_POWER_ACTIVE_LOW = 2'h3;
    localparam logic [1:0] AUX_BOOST_ASSIST_MODE = 2'h2;
    // Loss of poll action codes; code 3 behaves as none.
    localparam logic [1:0] AUX_ACTION_NONE = 2'h0;
    localparam logic [1:0] AUX_ACTION_ON = 2'h1;
    localparam logic [1:0] AUX_ACTION_OFF = 2'h2;
    // Reset values.
    localparam logic [1:0] AUX_MODE1_RST = AUX_MODE_INPUT;
    localparam logic [1:0] AUX_MODE2_RST = AUX_MODE_INPUT;
    localparam logic [1:0] AUX_MODE3_RST = AUX_BOOST_ASSIST_MODE;
    localparam logic [15:0] AUX_ON_PERIOD_RST = 16'h003C;
    localparam logic [15:0] AUX_OFF_PERIOD_RST = 16'h52F8;
    localparam logic [15:0] AUX_TIMEOUT_RST = 16'h003C;
    localparam logic [1:0] AUX_ACTION_RST = AUX_ACTION_NONE;
    localparam logic AUX_RANGE_RST = 1'b1;
    localparam logic [15:0] AUX_GAIN_RST = 16'h03E8;
    localparam logic [2:0] AUX_SHIFT_RST = 3'h6;
    localparam logic [2:0] AUX_SHIFT_MAX = 3'h6;
    // Scaling: full scale reading and the 4 mA point on the 0 to 20 mA scale.
    localparam logic [31:0] AUX_FULL_SCALE = 32'h0000_2710;
    localparam logic [31:0] AUX_LOOP_OFFSET = 32'h0000_07D0;
    // Timing.
    localparam longint AUX_CLK_HZ = 200_000_000;
    localparam longint AUX_TICK_S = 1;
    localparam int unsigned AUX_SEC_CYCLES = int'(AUX_CLK_HZ * AUX_TICK_S);
    localparam int AUX_PRESCALE_W = 28;
    typedef enum logic [1:0] {AUX_RADIO_IDLE, AUX_RADIO_ON, AUX_RADIO_OFF} aux_radio_e;
endpackage

// ### shared/aux_ana_if.sv
// Carrier between the channel controller and one analog scaling unit.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface aux_ana_if;
    logic sample_valid;
    logic [15:0] sample;
    logic current_loop_range;
    logic [15:0] gain;
    logic [2:0] shift;
    logic [13:0] reading;
    modport scaler (input sample_valid, sample, current_loop_range, gain, shift,
                    output reading);
    modport ctrl (output sample_valid, sample, current_loop_range, gain, shift,
                  input reading);
endinterface

// ### hw/aux_scale.sv
// Scales one raw converter sample into a 0 to 10000 reading.
// Assumes samples arrive on the system clock with a one-cycle valid strobe.
`timescale 1ns/1ps
module aux_scale
    import aux_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Sample and settings
    aux_ana_if.scaler ana
);
    logic [31:0] product;
    logic [31:0] scaled;
    logic [31:0] lifted;
    logic [31:0] adjusted;
    logic [13:0] nxt_reading;
    logic [13:0] reading_ff;

    // Gain and shift both act on every range.
    assign product = ana.sample * ana.gain;
    assign scaled = product >> ana.shift;

    always_comb begin
        lifted = scaled - AUX_LOOP_OFFSET;
        adjusted = scaled;
        if (ana.current_loop_range) begin
            // Below 4 mA is a broken loop and reads as zero.
            if (scaled <= AUX_LOOP_OFFSET) begin
                adjusted = '0;
            end else begin
                adjusted = lifted + (lifted >> 2);
            end
        end
        if (adjusted > AUX_FULL_SCALE) begin
            nxt_reading = AUX_FULL_SCALE[13:0];
        end else begin
            nxt_reading = adjusted[13:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reading_ff <= '0;
        end else if (ana.sample_valid) begin
            reading_ff <= nxt_reading;
        end
    end

    assign ana.reading = reading_ff;
endmodule

// ### hw/aux_io.sv
// Auxiliary channel controller: three two-way channels, radio power cycling,
// loss of poll loss_of_poll_action and two analog scaling units.
// Assumes polls, commands, settings and samples come from logic on sys_clk_in;
// only the channel pins are asynchronous.
//
// Overview of operation
// - First channel offers input, output, radio high, radio low; resets to input.
// - An input channel's synchronised pin level is always presented for reading.
// - First channel as output drives the level last commanded by the master.
// - Radio high mode drives the pin high while the radio should be on.
// - Radio low mode drives the pin low while the radio should be on.
// - Channels two and three: output, input or boost; reset to input, boost.
// - Boost mode drives the pin with the readout unit's boost request.
// - Radio on period counts only while channel one is in a radio mode.
// - An addressed poll keeps the radio on for the on period, default 60 s.
// - Then radio off for the off period, default 21240 s, then await a poll.
// - Action on: poll timeout switches commanded outputs on.
// - Action off: poll timeout switches commanded outputs off.
// - Loss_of_poll_action touches output channels only; action none, the default, ignores timeout.
// - Timeout in seconds, default 60, restarts on every poll.
// - Current loop range reads 0 at 4 mA, 10000 at 20 mA; default range.
// - Voltage range reads 0 at 0 V, 10000 at 5 V.
// - A factory gain constant, default 1000, scales analog readings.
// - A factory shift constant 0 to 6, default 6, scales analog readings.
`timescale 1ns/1ps
module aux_io
    import aux_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = AUX_SEC_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Channel pins
    input wire logic [2:0] aux_pin_in,
    output logic [2:0] aux_pin_out,
    output logic [2:0] aux_pin_oe_out,
    // Poll and output commands
    input wire logic poll_in,
    input wire logic [2:0] dout_wr_in,
    input wire logic [2:0] dout_val_in,
    input wire logic boost_req_in,
    // Settings, captured on cfg_load_in
    input wire logic cfg_load_in,
    input wire logic [1:0] first_side_channel_in,
    input wire logic [1:0] second_side_channel_in,
    input wire logic [1:0] third_side_channel_in,
    input wire logic [15:0] radio_on_period_in,
    input wire logic [15:0] radio_off_period_in,
    input wire logic [1:0] loss_of_poll_action_in,
    input wire logic [15:0] loss_of_poll_timeout_in,
    input wire logic [1:0] current_loop_range_in,
    input wire logic [15:0] converter_gain_constant_in,
    input wire logic [2:0] converter_scale_shift_in,
    // Analog samples
    input wire logic [1:0] adc_valid_in,
    input wire logic [15:0] analog_channel_one_in,
    input wire logic [15:0] analog_channel_two_in,
    // Status
    output logic [2:0] din_level_out,
    output logic radio_on_out,
    output logic [1:0] radio_state_out,
    output logic loss_of_poll_action_active_out,
    output logic [13:0] analog_channel_one_out,
    output logic [13:0] analog_channel_two_out
);
    logic [1:0] mode_ff [3];
    logic [15:0] on_period_ff;
    logic [15:0] off_period_ff;
    logic [1:0] action_ff;
    logic [15:0] timeout_ff;
    logic [1:0] range_ff;
    logic [15:0] gain_ff;
    logic [2:0] shift_ff;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] din_level_ff;
    logic [AUX_PRESCALE_W-1:0] prescale_ff;
    logic tick_ff;
    aux_radio_e radio_ff;
    logic [15:0] radio_cnt_ff;
    logic [15:0] fs_cnt_ff;
    logic fs_expired_ff;
    logic fs_armed;
    logic fs_event;
    logic fs_level;
    logic [2:0] dout_ff;
    logic [2:0] nxt_pin;
    logic [2:0] nxt_oe;
    logic [2:0] pin_ff;
    logic [2:0] oe_ff;
    logic radio_mode;
    logic radio_on;
    logic [15:0] raw [2];
    aux_ana_if ana_if [2] ();

    // Settings register; each field resets to its default.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_ff[0] <= AUX_MODE1_RST;
            mode_ff[1] <= AUX_MODE2_RST;
            mode_ff[2] <= AUX_MODE3_RST;
            on_period_ff <= AUX_ON_PERIOD_RST;
            off_period_ff <= AUX_OFF_PERIOD_RST;
            action_ff <= AUX_ACTION_RST;
            timeout_ff <= AUX_TIMEOUT_RST;
            range_ff <= {AUX_RANGE_RST, AUX_RANGE_RST};
            gain_ff <= AUX_GAIN_RST;
            shift_ff <= AUX_SHIFT_RST;
        end else if (cfg_load_in) begin
            mode_ff[0] <= first_side_channel_in;
            mode_ff[1] <= second_side_channel_in;
            mode_ff[2] <= third_side_channel_in;
            on_period_ff <= radio_on_period_in;
            off_period_ff <= radio_off_period_in;
            action_ff <= loss_of_poll_action_in;
            timeout_ff <= loss_of_poll_timeout_in;
            range_ff <= current_loop_range_in;
            gain_ff <= converter_gain_constant_in;
            // An out of range shift is refused and the old value kept.
            if (converter_scale_shift_in <= AUX_SHIFT_MAX) begin
                shift_ff <= converter_scale_shift_in;
            end
        end
    end

    // Pin levels are asynchronous; two stages before anything reads them.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            din_level_ff <= '0;
        end else begin
            sync1_ff <= aux_pin_in;
            sync2_ff <= sync1_ff;
            din_level_ff <= sync2_ff;
        end
    end

    // One second tick.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prescale_ff <= '0;
            tick_ff <= 1'b0;
        end else if (prescale_ff == AUX_PRESCALE_W'(SEC_CYCLES - 1)) begin
            prescale_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            prescale_ff <= prescale_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign radio_mode = (mode_ff[0] == AUX_RADIO_POWER_ACTIVE_HIGH) ||
                        (mode_ff[0] == AUX_RADIO_POWER_ACTIVE_LOW);

    // Radio power cycling. The radio stays on while idle, otherwise no poll
    // could ever reach the device; polls during the off period are not seen.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            radio_ff <= AUX_RADIO_IDLE;
            radio_cnt_ff <= '0;
        end else if (!radio_mode) begin
            radio_ff <= AUX_RADIO_IDLE;
            radio_cnt_ff <= '0;
        end else begin
            unique case (radio_ff)
                AUX_RADIO_IDLE: begin
                    if (poll_in) begin
                        radio_ff <= AUX_RADIO_ON;
                        radio_cnt_ff <= on_period_ff;
                    end
                end
                AUX_RADIO_ON: begin
                    if (poll_in) begin
                        radio_cnt_ff <= on_period_ff;
                    end else if (tick_ff) begin
                        if (radio_cnt_ff <= 16'h0001) begin
                            radio_ff <= AUX_RADIO_OFF;
                            radio_cnt_ff <= off_period_ff;
                        end else begin
                            radio_cnt_ff <= radio_cnt_ff - 1'b1;
                        end
                    end
                end
                AUX_RADIO_OFF: begin
                    if (tick_ff) begin
                        if (radio_cnt_ff <= 16'h0001) begin
                            radio_ff <= AUX_RADIO_IDLE;
                            radio_cnt_ff <= '0;
                        end else begin
                            radio_cnt_ff <= radio_cnt_ff - 1'b1;
                        end
                    end
                end
                default: begin
                    radio_ff <= AUX_RADIO_IDLE;
                    radio_cnt_ff <= '0;
                end
            endcase
        end
    end

    assign radio_on = (radio_ff != AUX_RADIO_OFF);

    // Seconds since the last poll, saturating so it never wraps to fresh.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fs_cnt_ff <= '0;
        end else if (poll_in) begin
            fs_cnt_ff <= '0;
        end else if (tick_ff && (fs_cnt_ff != 16'hFFFF)) begin
            fs_cnt_ff <= fs_cnt_ff + 1'b1;
        end
    end

    assign fs_armed = (action_ff == AUX_ACTION_ON) ||
                      (action_ff == AUX_ACTION_OFF);
    assign fs_event = fs_armed && !poll_in && (fs_cnt_ff >= timeout_ff) &&
                      !fs_expired_ff;
    assign fs_level = (action_ff == AUX_ACTION_ON);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fs_expired_ff <= 1'b0;
        end else if (poll_in || !fs_armed) begin
            fs_expired_ff <= 1'b0;
        end else if (fs_event) begin
            fs_expired_ff <= 1'b1;
        end
    end

    // Per channel command latch and pin drive.
    for (genvar i = 0; i < AUX_CHANNELS; i++) begin : g_chan
        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                dout_ff[i] <= 1'b0;
            end else if (dout_wr_in[i]) begin
                // A command in the expiry cycle wins over the loss_of_poll_action level.
                dout_ff[i] <= dout_val_in[i];
            end else if (fs_event && (mode_ff[i] == AUX_MODE_OUTPUT)) begin
                dout_ff[i] <= fs_level;
            end
        end

        if (i == 0) begin : g_first
            always_comb begin
                nxt_pin[i] = 1'b0;
                nxt_oe[i] = 1'b1;
                unique case (mode_ff[i])
                    AUX_MODE_INPUT: nxt_oe[i] = 1'b0;
                    AUX_MODE_OUTPUT: nxt_pin[i] = dout_ff[i];
                    AUX_RADIO_POWER_ACTIVE_HIGH: nxt_pin[i] = radio_on;
                    AUX_RADIO_POWER_ACTIVE_LOW: nxt_pin[i] = !radio_on;
                endcase
            end
        end else begin : g_other
            always_comb begin
                nxt_pin[i] = 1'b0;
                nxt_oe[i] = 1'b1;
                unique case (mode_ff[i])
                    AUX_MODE_OUTPUT: nxt_pin[i] = dout_ff[i];
                    AUX_BOOST_ASSIST_MODE: nxt_pin[i] = boost_req_in;
                    default: nxt_oe[i] = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_ff <= '0;
            oe_ff <= '0;
        end else begin
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
        end
    end

    // Analog scaling units.
    assign raw[0] = analog_channel_one_in;
    assign raw[1] = analog_channel_two_in;
    for (genvar a = 0; a < AUX_ANALOG; a++) begin : g_ana
        assign ana_if[a].sample_valid = adc_valid_in[a];
        assign ana_if[a].sample = raw[a];
        assign ana_if[a].current_loop_range = range_ff[a];
        assign ana_if[a].gain = gain_ff;
        assign ana_if[a].shift = shift_ff;
        aux_scale u_scale (
            .sys_clk_in(sys_clk_in),
            .rst_n_in(rst_n_in),
            .ana(ana_if[a].scaler)
        );
    end

    // Status outputs.
    logic radio_on_ff;
    logic [1:0] radio_state_ff;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            radio_on_ff <= 1'b1;
            radio_state_ff <= '0;
        end else begin
            radio_on_ff <= radio_on;
            radio_state_ff <= radio_ff;
        end
    end

    assign aux_pin_out = pin_ff;
    assign aux_pin_oe_out = oe_ff;
    assign din_level_out = din_level_ff;
    assign radio_on_out = radio_on_ff;
    assign radio_state_out = radio_state_ff;
    assign loss_of_poll_action_active_out = fs_expired_ff;
    assign analog_channel_one_out = ana_if[0].reading;
    assign analog_channel_two_out = ana_if[1].reading;
endmodule

// ### verification/aux_field_model.sv
// Far-side model of the three channel wires and whatever hangs on them.
// Assumes the testbench sets the level that the outside world drives on released wires.
`timescale 1ns/1ps
module aux_field_model (
    // Design side
    input wire logic [2:0] pin_drive_in,
    input wire logic [2:0] pin_oe_in,
    // Outside world
    input wire logic [2:0] ext_level_in,
    output logic [2:0] pin_level_out
);
    // A released wire shows the outside level, never a stale copy of the design's drive.
    assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & ext_level_in);
endmodule

// ### verification/aux_io_assertions.sv
// Concurrent checks on the ports of the auxiliary channel controller.
// Assumes one clock domain and that channel modes change only on cfg_load_in.
`timescale 1ns/1ps
module aux_io_checker
    import aux_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = AUX_SEC_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Requests
    input wire logic [2:0] aux_pin_in,
    input wire logic poll_in,
    input wire logic cfg_load_in,
    input wire logic [1:0] first_side_channel_in,
    input wire logic [1:0] adc_valid_in,
    // Outputs
    input wire logic [2:0] aux_pin_out,
    input wire logic [2:0] aux_pin_oe_out,
    input wire logic [2:0] din_level_out,
    input wire logic radio_on_out,
    input wire logic [1:0] radio_state_out,
    input wire logic loss_of_poll_action_active_out,
    input wire logic [13:0] analog_channel_one_out
);
    logic [1:0] m1_ff;
    logic [2:0] up_ff;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            m1_ff <= AUX_MODE1_RST;
        end else if (cfg_load_in) begin
            m1_ff <= first_side_channel_in;
        end
    end
    // History sampled inside reset is not trusted until four edges have passed.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_ff <= 3'h0;
        end else if (up_ff != 3'h4) begin
            up_ff <= up_ff + 3'h1;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence m1_held_s(logic [1:0] v);
        (m1_ff == v) [*3];
    endsequence
    hi_pin_a: assert property (m1_held_s(AUX_RADIO_POWER_ACTIVE_HIGH)
        |-> aux_pin_oe_out[0] && aux_pin_out[0] == radio_on_out) else $error("high pin");
    lo_pin_a: assert property (m1_held_s(AUX_RADIO_POWER_ACTIVE_LOW)
        |-> aux_pin_oe_out[0] && aux_pin_out[0] == !radio_on_out) else $error("low pin");
    in_oe_a: assert property (m1_held_s(AUX_MODE_INPUT) |-> !aux_pin_oe_out[0])
        else $error("input driven");
    idle_force_a: assert property (m1_held_s(AUX_MODE_INPUT) |-> radio_state_out == 2'h0)
        else $error("radio timing while not in radio mode");
    din_sync_a: assert property (up_ff == 3'h4 |-> din_level_out == $past(aux_pin_in, 3))
        else $error("input level");
    off_exit_a: assert property (radio_state_out == 2'h2 |=> radio_state_out != 2'h1)
        else $error("poll during off period");
    idle_poll_a: assert property (m1_held_s(AUX_RADIO_POWER_ACTIVE_HIGH) ##0
        (radio_state_out == 2'h0 && poll_in && !cfg_load_in) |-> ##2 radio_state_out == 2'h1)
        else $error("poll did not start on period");
    poll_clear_a: assert property (poll_in |=> !loss_of_poll_action_active_out)
        else $error("poll did not clear loss_of_poll_action");
    ana_hold_a: assert property (up_ff == 3'h4 && !$past(adc_valid_in[0])
        |-> $stable(analog_channel_one_out) && analog_channel_one_out <= 14'h2710)
        else $error("reading moved or out of range");
endmodule
bind aux_io aux_io_checker #(.SEC_CYCLES(SEC_CYCLES)) aux_io_checker_i (.*);

// ### verification/aux_io_tb.sv
// Self-checking bench for the auxiliary channel controller.
// Assumes a 200 MHz clock and a one second tick shortened to SEC cycles.
`timescale 1ns/1ps
module aux_io_tb;
    import aux_pkg::*;
    localparam int unsigned SEC = 10;
    localparam int KP = 0;
    localparam int KO = 1;
    localparam int KD = 2;
    localparam int KS = 3;
    localparam int KF = 4;
    localparam int KA = 5;
    typedef struct {int due; int kind; logic [15:0] v;} aux_note_s;
    logic sys_clk_in = 1'b0;
    logic rst_n_in, poll_in, boost_req_in, cfg_load_in, radio_on_out, loss_of_poll_action_active_out;
    logic [2:0] aux_pin_in, aux_pin_out, aux_pin_oe_out, dout_wr_in, dout_val_in, din_level_out;
    logic [2:0] ext = 3'h1;
    logic [2:0] sh = AUX_SHIFT_RST;
    logic [1:0] first_side_channel_in = AUX_MODE_INPUT;
    logic [1:0] second_side_channel_in = AUX_MODE_INPUT;
    logic [1:0] third_side_channel_in = AUX_BOOST_ASSIST_MODE;
    logic [1:0] loss_of_poll_action_in = AUX_ACTION_NONE;
    logic [1:0] current_loop_range_in = 2'h3;
    logic [1:0] adc_valid_in, radio_state_out;
    logic [15:0] radio_on_period_in = 16'h0003;
    logic [15:0] radio_off_period_in = 16'h0006;
    logic [15:0] loss_of_poll_timeout_in = 16'h0002;
    logic [15:0] converter_gain_constant_in = AUX_GAIN_RST;
    logic [2:0] converter_scale_shift_in = AUX_SHIFT_RST;
    logic [15:0] analog_channel_one_in, analog_channel_two_in;
    logic [13:0] analog_channel_one_out, analog_channel_two_out;
    int cyc = 0;
    int failures = 0;
    int samples_checked = 0;
    aux_note_s q[$];
    aux_note_s n;
    aux_io #(.SEC_CYCLES(SEC)) aux_io_i (.*);
    aux_field_model aux_field_model_i (
        .pin_drive_in(aux_pin_out),
        .pin_oe_in(aux_pin_oe_out),
        .ext_level_in(ext),
        .pin_level_out(aux_pin_in)
    );
    always #2.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) cyc <= cyc + 1;
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk_in);
    endtask
    task automatic note(input int kind, input logic [15:0] v);
        q.push_back('{cyc + 1, kind, v});
    endtask
    task automatic cmp_bits(input logic [2:0] a, input logic [2:0] e);
        samples_checked++;
        if (a !== e) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
        samples_checked++;
        if (a !== e) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, a, e);
        end
    endtask
    // Pins are compared only where driven; a released pin's drive level means nothing.
    always @(negedge sys_clk_in) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            n = q.pop_front();
            case (n.kind)
                KP: cmp_bits(aux_pin_out & aux_pin_oe_out, n.v[2:0]);
                KO: cmp_bits(aux_pin_oe_out, n.v[2:0]);
                KD: cmp_bits(din_level_out, n.v[2:0]);
                KS: cmp_word({13'h0, radio_on_out, radio_state_out}, n.v);
                KF: cmp_word({15'h0, loss_of_poll_action_active_out}, n.v);
                KA: cmp_word({2'h0, analog_channel_one_out}, n.v);
                default: cmp_word({2'h0, analog_channel_two_out}, n.v);
            endcase
        end
    end
    function automatic logic [15:0] scale(input logic [15:0] r, input logic [15:0] g,
                                          input logic [2:0] s, input logic cur);
        logic [31:0] x;
        x = ({16'h0, r} * {16'h0, g}) >> s;
        if (cur) begin
            x = (x <= AUX_LOOP_OFFSET) ? 32'h0 : (x - AUX_LOOP_OFFSET) + ((x - AUX_LOOP_OFFSET) >> 2);
        end
        return (x > AUX_FULL_SCALE) ? AUX_FULL_SCALE[15:0] : x[15:0];
    endfunction
    task automatic load;
        cfg_load_in = 1'b1;
        tick(1);
        cfg_load_in = 1'b0;
        tick(3);
    endtask
    task automatic send_poll;
        poll_in = 1'b1;
        tick(1);
        poll_in = 1'b0;
    endtask
    task automatic wr(input logic [2:0] b, input logic [2:0] v);
        dout_wr_in = b;
        dout_val_in = v;
        tick(1);
    endtask
    task automatic sample(input logic [15:0] r1, input logic [15:0] r2);
        analog_channel_one_in = r1;
        analog_channel_two_in = r2;
        adc_valid_in = 2'h3;
        tick(1);
        adc_valid_in = 2'h0;
        tick(1);
    endtask
    task automatic results;
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst_n_in = 1'b0;
        {poll_in, boost_req_in, cfg_load_in, dout_wr_in, dout_val_in, adc_valid_in} = '0;
        {analog_channel_one_in, analog_channel_two_in} = '0;
        void'($urandom(80061));
        tick(2);
        rst_n_in = 1'b1;
        tick(3);
        note(KO, 16'h0004);
        note(KS, 16'h0004);
        note(KD, 16'h0001);
        boost_req_in = 1'b1;
        tick(4);
        note(KP, 16'h0004);
        note(KD, 16'h0005);
        sample(16'h0280, 16'h00A0);
        note(KA, 16'h2710);
        note(KA + 1, 16'h0271);
        third_side_channel_in = AUX_MODE_INPUT;
        load();
        note(KO, 16'h0000);
        repeat (6) begin
            ext = 3'($urandom);
            tick(4);
            note(KD, {13'h0, ext});
            tick(1);
        end
        first_side_channel_in = AUX_MODE_OUTPUT;
        second_side_channel_in = AUX_MODE_OUTPUT;
        load();
        wr(3'h3, 3'h3);
        wr(3'h1, 3'h0);
        dout_wr_in = 3'h0;
        tick(2);
        note(KP, 16'h0002);
        note(KO, 16'h0003);
        first_side_channel_in = AUX_MODE_INPUT;
        load();
        send_poll();
        tick(3);
        note(KS, 16'h0004);
        first_side_channel_in = AUX_RADIO_POWER_ACTIVE_HIGH;
        load();
        note(KP, 16'h0003);
        send_poll();
        tick(4);
        note(KS, 16'h0005);
        tick(35);
        note(KS, 16'h0002);
        note(KP, 16'h0002);
        send_poll();
        tick(20);
        note(KS, 16'h0002);
        tick(50);
        note(KS, 16'h0004);
        first_side_channel_in = AUX_RADIO_POWER_ACTIVE_LOW;
        load();
        note(KP, 16'h0002);
        send_poll();
        tick(40);
        note(KP, 16'h0003);
        first_side_channel_in = AUX_MODE_INPUT;
        loss_of_poll_action_in = AUX_ACTION_ON;
        load();
        send_poll();
        wr(3'h2, 3'h0);
        dout_wr_in = 3'h0;
        tick(4);
        note(KP, 16'h0000);
        tick(30);
        note(KP, 16'h0002);
        note(KF, 16'h0001);
        loss_of_poll_action_in = AUX_ACTION_OFF;
        load();
        send_poll();
        wr(3'h2, 3'h2);
        dout_wr_in = 3'h0;
        repeat (6) begin
            tick(6);
            send_poll();
        end
        note(KP, 16'h0002);
        note(KF, 16'h0000);
        tick(30);
        note(KP, 16'h0000);
        loss_of_poll_action_in = AUX_ACTION_NONE;
        load();
        wr(3'h2, 3'h2);
        dout_wr_in = 3'h0;
        tick(40);
        note(KP, 16'h0002);
        note(KF, 16'h0000);
        // A shift above the limit is refused, so the bench keeps its own copy of the last good one.
        repeat (16) begin
            current_loop_range_in = 2'($urandom);
            converter_gain_constant_in = 16'($urandom_range(1, 2000));
            converter_scale_shift_in = 3'($urandom);
            if (converter_scale_shift_in <= AUX_SHIFT_MAX) sh = converter_scale_shift_in;
            load();
            sample(16'($urandom_range(0, 4095)), 16'($urandom_range(0, 4095)));
            note(KA, scale(analog_channel_one_in, converter_gain_constant_in, sh, current_loop_range_in[0]));
            note(KA + 1, scale(analog_channel_two_in, converter_gain_constant_in, sh, current_loop_range_in[1]));
        end
        tick(5);
        results();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        results();
    end
endmodule
